// *** core/ppsg_top.v ***
// Pulse per second generator with APB register access.
// Assumes epoch strobes, scale time and solution age come from the
// solution engine on CLK_SYS; the pulse pin drives an external device.
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "ppsg_defs.vh"
module ppsg_top #(
  parameter CYC_PER_MS = `PPSG_CLK_MHZ * `PPSG_MS_US,
  parameter PULSE_WIDTH_CYC = `PPSG_PULSE_WIDTH_US * `PPSG_CLK_MHZ
) (
  input wire CLK_SYS,
  input wire RESET_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output wire PREADY,
  output reg PSLVERR,
  input wire [3:0] SCALE_EPOCH,
  input wire [31:0] SCALE_TIME,
  input wire [15:0] SOLUTION_AGE,
  output wire [1:0] SCALE_SEL,
  output wire PPS_OUT,
  output reg [31:0] TOD_TIME,
  output reg TOD_STROBE
);
  localparam PW = 27;

  reg [3:0] ctrl_q;
  reg [13:0] interval_q;
  reg [23:0] delay_q;
  reg [15:0] age_limit_q;
  reg [PW-1:0] phase_q;
  reg [PW-1:0] phase_d;
  reg extrap_q;
  reg fired_q;
  reg [31:0] edge_time_q;
  reg [13:0] interval_ms;
  reg [PW-1:0] fire_at;
  wire [PW-1:0] period_cyc;
  wire [PW-1:0] delay_cyc;
  wire [1:0] scale;
  wire is_local;
  wire epoch;
  wire suppressed;
  wire fire;
  wire pulse_active;
  wire pulse_done;
  wire wr_en;
  wire rd_en;
  wire addr_ok;

  assign scale = ctrl_q[`PPSG_CTRL_SCALE_HI:`PPSG_CTRL_SCALE_LO];
  assign SCALE_SEL = scale;
  assign is_local = (scale == `PPSG_SCALE_LOCAL);

  // APB decode, zero wait states
  assign PREADY = 1'b1;
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign rd_en = PSEL && PENABLE && !PWRITE;
  assign addr_ok = (PADDR == `PPSG_OFS_CTRL) || (PADDR == `PPSG_OFS_INTERVAL) ||
                   (PADDR == `PPSG_OFS_DELAY) || (PADDR == `PPSG_OFS_AGE_LIMIT) ||
                   (PADDR == `PPSG_OFS_STATUS) || (PADDR == `PPSG_OFS_TOD);

  // Register writes
  always @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      ctrl_q <= `PPSG_RST_CTRL;
      interval_q <= `PPSG_RST_INTERVAL;
      delay_q <= `PPSG_RST_DELAY;
      age_limit_q <= `PPSG_RST_AGE_LIMIT;
    end else if (wr_en) begin
      case (PADDR)
        `PPSG_OFS_CTRL: ctrl_q <= PWDATA[3:0];
        `PPSG_OFS_INTERVAL: interval_q <= PWDATA[13:0];
        `PPSG_OFS_DELAY: delay_q <= PWDATA[23:0];
        `PPSG_OFS_AGE_LIMIT: age_limit_q <= PWDATA[15:0];
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // Read data and error answer
  always @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      PRDATA <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else begin
      PSLVERR <= 1'b0;
      if (PSEL && !PENABLE) begin
        PSLVERR <= !addr_ok;
        case (PADDR)
          `PPSG_OFS_CTRL: PRDATA <= {28'h0000000, ctrl_q};
          `PPSG_OFS_INTERVAL: PRDATA <= {18'h00000, interval_q};
          `PPSG_OFS_DELAY: PRDATA <= {8'h00, delay_q};
          `PPSG_OFS_AGE_LIMIT: PRDATA <= {16'h0000, age_limit_q};
          `PPSG_OFS_STATUS: PRDATA <= {29'h00000000, extrap_q, pulse_active, suppressed};
          `PPSG_OFS_TOD: PRDATA <= TOD_TIME;
          default: PRDATA <= 32'h00000000;
        endcase
      end else if (rd_en) begin
        PSLVERR <= !addr_ok;
      end
    end
  end

  // Clamp interval into the permitted range
  always @* begin
    if (interval_q < `PPSG_INTERVAL_MIN_MS) begin
      interval_ms = `PPSG_INTERVAL_MIN_MS;
    end else if (interval_q > `PPSG_INTERVAL_MAX_MS) begin
      interval_ms = `PPSG_INTERVAL_MAX_MS;
    end else begin
      interval_ms = interval_q;
    end
  end

  assign period_cyc = interval_ms * CYC_PER_MS[PW-1:0];
  assign delay_cyc = {3'h0, delay_q};

  // Fire point moves earlier as delay grows
  always @* begin
    if (delay_cyc >= period_cyc) begin
      fire_at = {PW{1'b0}};
    end else if (delay_cyc == {PW{1'b0}}) begin
      fire_at = {PW{1'b0}};
    end else begin
      fire_at = period_cyc - delay_cyc;
    end
  end

  // Epoch of the chosen scale, local scale free runs
  assign epoch = !is_local && SCALE_EPOCH[scale];

  // Phase within the interval, realigned at each epoch
  always @* begin
    if (epoch) begin
      phase_d = {PW{1'b0}};
    end else if (phase_q >= period_cyc - {{(PW-1){1'b0}}, 1'b1}) begin
      phase_d = {PW{1'b0}};
    end else begin
      phase_d = phase_q + {{(PW-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      phase_q <= {PW{1'b0}};
      extrap_q <= 1'b0;
      fired_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      fired_q <= fire;
      if (epoch) begin
        extrap_q <= 1'b0;
      end else if (!is_local && phase_d == {PW{1'b0}}) begin
        extrap_q <= 1'b1;
      end
    end
  end

  // Age gate, bypassed on the local clock scale
  assign suppressed = !is_local && (SOLUTION_AGE > age_limit_q);
  assign fire = ctrl_q[`PPSG_CTRL_ENABLE] && !suppressed && (phase_q == fire_at) &&
                !fired_q;

  ppsg_pulse #(
    .WIDTH_CYC(PULSE_WIDTH_CYC),
    .CW(24)
  ) u_pulse (
    .clk(CLK_SYS),
    .reset_n(RESET_N),
    .start(fire),
    .falling(ctrl_q[`PPSG_CTRL_FALLING]),
    .pin_q(PPS_OUT),
    .active(pulse_active),
    .done_q(pulse_done)
  );

  // Time at leading edge, reported once the pulse ends
  always @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      edge_time_q <= 32'h00000000;
      TOD_TIME <= 32'h00000000;
      TOD_STROBE <= 1'b0;
    end else begin
      TOD_STROBE <= pulse_done;
      if (fire && !pulse_active) begin
        edge_time_q <= SCALE_TIME;
      end
      if (pulse_done) begin
        TOD_TIME <= edge_time_q;
      end
    end
  end
endmodule

// *** core/ppsg_defs.vh ***
// Constants of the pulse per second generator: offsets, fields, resets, timing.
// Assumes a 10 MHz system clock and an APB slave with 32-bit data.
//
// Overview of operation
// - Pulse interval programmable from 10 ms to 10 s.
// - Rising active edge by default, falling selectable.
// - Larger delay setting moves the pulse earlier.
// - Align to satellite, UTC, local or Russian scale.
// - Missing solutions: extrapolate from the last one.
// - Suppress pulses while solution age exceeds limit.
// - Local receiver clock ignores the age limit.
// - Time-of-day report follows pulse, refers to edge.
`ifndef PPSG_DEFS_VH
`define PPSG_DEFS_VH

// Register byte offsets
`define PPSG_OFS_CTRL 8'h00
`define PPSG_OFS_INTERVAL 8'h04
`define PPSG_OFS_DELAY 8'h08
`define PPSG_OFS_AGE_LIMIT 8'h0C
`define PPSG_OFS_STATUS 8'h10
`define PPSG_OFS_TOD 8'h14

// Control fields
`define PPSG_CTRL_ENABLE 0
`define PPSG_CTRL_FALLING 1
`define PPSG_CTRL_SCALE_LO 2
`define PPSG_CTRL_SCALE_HI 3

// Status fields
`define PPSG_STAT_SUPPRESSED 0
`define PPSG_STAT_ACTIVE 1
`define PPSG_STAT_EXTRAP 2

// Time scale codes
`define PPSG_SCALE_SATELLITE 2'h0
`define PPSG_SCALE_UTC 2'h1
`define PPSG_SCALE_LOCAL 2'h2
`define PPSG_SCALE_RUSSIAN 2'h3

// Reset values
`define PPSG_RST_CTRL 4'h1
`define PPSG_RST_INTERVAL 14'h03E8
`define PPSG_RST_DELAY 24'h000000
`define PPSG_RST_AGE_LIMIT 16'h000A

// Interval limits in milliseconds
`define PPSG_INTERVAL_MIN_MS 14'h000A
`define PPSG_INTERVAL_MAX_MS 14'h2710

// Timing
`define PPSG_CLK_MHZ 10
`define PPSG_MS_US 1000
`define PPSG_PULSE_WIDTH_US 1000

`endif

// *** core/ppsg_pulse.v ***
// Pulse width timer and polarity stage of the pulse generator.
// Assumes a start strobe from logic on the same clock.
`timescale 1ns/1ps
module ppsg_pulse #(
  parameter WIDTH_CYC = 10000,
  parameter CW = 24
) (
  input wire clk,
  input wire reset_n,
  input wire start,
  input wire falling,
  output reg pin_q,
  output wire active,
  output reg done_q
);
  reg [CW-1:0] cnt_q;
  reg act_q;
  wire done_end;

  // Hold the pulse for a fixed count, flag its end
  always @(posedge clk) begin
    if (!reset_n) begin
      cnt_q <= {CW{1'b0}};
      act_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start && !act_q) begin
        act_q <= 1'b1;
        cnt_q <= WIDTH_CYC[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
      end else if (act_q) begin
        if (cnt_q == {CW{1'b0}}) begin
          act_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // Output level with selectable active edge
  always @(posedge clk) begin
    if (!reset_n) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= (start || (act_q && !done_end)) ^ falling;
    end
  end

  // Last counted cycle of the pulse
  assign done_end = act_q && (cnt_q == {CW{1'b0}});
  assign active = act_q;
endmodule

// *** tb/ppsg_checker.sv ***
// Port checker of the pulse generator top.
// Assumes bind onto ppsg_top, counts shortened to a 3-cycle pulse, age limit left at reset.
`timescale 1ns/1ps
module ppsg_checker (
  input wire CLK_SYS,
  input wire RESET_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  input wire PREADY,
  input wire PSLVERR,
  input wire [15:0] SOLUTION_AGE,
  input wire [1:0] SCALE_SEL,
  input wire PPS_OUT,
  input wire [31:0] TOD_TIME,
  input wire TOD_STROBE
);
  reg fall_q;
  wire wr = PSEL && PENABLE && PWRITE;
  wire sup = SOLUTION_AGE > 16'h000A && SCALE_SEL != 2'h2;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  // Shadow of the polarity bit
  always @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      fall_q <= 1'b0;
    end else if (wr && PADDR == 8'h00) begin
      fall_q <= PWDATA[1];
    end
  end
  sequence s_lead;
    $rose(PPS_OUT) && !fall_q;
  endsequence
  sequence s_body;
    PPS_OUT[*2] ##[0:2] !PPS_OUT;
  endsequence
  chk_pulse_width: assert property (s_lead |-> s_body) else $error("pulse width");
  chk_tod_follows: assert property (s_lead |-> ##[2:8] TOD_STROBE) else $error("no tod");
  chk_tod_once: assert property (TOD_STROBE |=> !TOD_STROBE) else $error("tod twice");
  chk_tod_moves: assert property ($changed(TOD_TIME) |-> TOD_STROBE) else $error("tod moved");
  chk_scale_sel: assert property (wr && PADDR == 8'h00 |=> SCALE_SEL == $past(PWDATA[3:2]))
    else $error("scale select");
  chk_age_stop: assert property (sup[*8] |-> !($rose(PPS_OUT) && !fall_q))
    else $error("pulse while stale");
  chk_bad_addr: assert property (PSEL && PENABLE && PADDR > 8'h14 |-> PSLVERR)
    else $error("no slave error");
  chk_ready_now: assert property (PSEL |-> PREADY) else $error("not ready");
endmodule

// *** tb/ppsg_sync_dev.sv ***
// Model of the external device that synchronises to the pulse pin.
// Assumes pin, strobe and time come from the generator on the same clock.
`timescale 1ns/1ps
module ppsg_sync_dev (
  input wire clk,
  input wire pin,
  input wire falling,
  input wire strobe,
  input wire [31:0] tod,
  output reg orphan,
  output wire [31:0] synced
);
  reg last_q = 1'b0;
  reg armed_q = 1'b0;
  reg [31:0] synced_q = 32'h0;
  initial orphan = 1'b0;
  assign synced = synced_q;
  // Arm on a leading edge, take the sentence that follows it
  always @(posedge clk) begin
    last_q <= pin ^ falling;
    if ((pin ^ falling) && !last_q) armed_q <= 1'b1;
    if (strobe) begin
      orphan <= orphan | !armed_q;
      armed_q <= 1'b0;
      synced_q <= tod;
    end
  end
endmodule

// *** tb/ppsg_tb.sv ***
// Self-checking bench of the pulse generator with a synchronising device.
// Assumes 10 cycles a millisecond and a 3-cycle pulse set at the instance.
`timescale 1ns/1ps
`define CHK(n, e, v) begin num_checks++; if ((v) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %0h got %0h", n, e, v); end end
module testbench;
  reg CLK_SYS = 1'b0;
  reg RESET_N = 1'b0;
  reg PSEL = 1'b0;
  reg PENABLE = 1'b0;
  reg PWRITE = 1'b0;
  reg [7:0] PADDR = 8'h00;
  reg [31:0] PWDATA = 32'h0;
  reg [3:0] SCALE_EPOCH = 4'h0;
  reg [31:0] SCALE_TIME = 32'h0;
  reg [15:0] SOLUTION_AGE = 16'h0;
  wire [31:0] PRDATA, TOD_TIME;
  wire PREADY, PSLVERR, PPS_OUT, TOD_STROBE, orphan;
  wire [1:0] SCALE_SEL;
  wire [31:0] dev_time;
  int error_cnt = 0, num_checks = 0, cyc = 0, nlead = 0, tlead = 0, tep = 0, n = 0;
  reg [31:0] tsc, rd;
  reg pol = 1'b0, pl = 1'b0, er;
  ppsg_top #(.CYC_PER_MS(10), .PULSE_WIDTH_CYC(3)) DUT (.CLK_SYS, .RESET_N, .PSEL, .PENABLE,
    .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .SCALE_EPOCH, .SCALE_TIME,
    .SOLUTION_AGE, .SCALE_SEL, .PPS_OUT, .TOD_TIME, .TOD_STROBE);
  ppsg_sync_dev dev (.clk(CLK_SYS), .pin(PPS_OUT), .falling(pol), .strobe(TOD_STROBE),
    .tod(TOD_TIME), .orphan(orphan), .synced(dev_time));
  // Clock, running scale time and leading edge monitor
  initial forever #50 CLK_SYS = ~CLK_SYS;
  always @(posedge CLK_SYS) begin
    SCALE_TIME <= SCALE_TIME + 32'h1;
    cyc++;
    pl <= PPS_OUT ^ pol;
    if (SCALE_EPOCH[0]) tep = cyc;
    if ((PPS_OUT ^ pol) && !pl) begin
      nlead++;
      tlead = cyc;
      tsc = SCALE_TIME;
    end
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task fail;
    error_cnt++;
    report_and_stop;
  endtask
  task tick(input int k);
    repeat (k) @(posedge CLK_SYS);
  endtask
  // One APB transfer, held until pready is seen
  task apb(input w, input [7:0] a, input [31:0] d);
    int i;
    @(posedge CLK_SYS);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    i = 0;
    do begin @(posedge CLK_SYS); i++; end while (PREADY !== 1'b1 && i < 20);
    if (i == 20) fail;
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task rchk(input [7:0] a, input [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask
  task wait_lead;
    int m, i;
    m = nlead;
    for (i = 0; i < 300 && nlead == m; i++) @(posedge CLK_SYS);
    if (nlead == m) fail;
  endtask
  task epoch_lead;
    @(posedge CLK_SYS);
    SCALE_EPOCH <= 4'h1;
    @(posedge CLK_SYS);
    SCALE_EPOCH <= 4'h0;
    // Let a pulse launched before the epoch pass first
    tick(5);
    wait_lead;
  endtask
  task run(input [31:0] c, input [15:0] age);
    int m;
    apb(1'b1, 8'h00, c);
    SOLUTION_AGE <= age;
    tick(20);
    m = nlead;
    tick(250);
    n = nlead - m;
  endtask
  // Reset values, interval field, unmapped access; clamp shows in the gap test
  task t_regs;
    rchk(8'h00, 32'h1, "ctrl");
    rchk(8'h04, 32'h3E8, "interval");
    rchk(8'h0C, 32'hA, "age limit");
    apb(1'b1, 8'h04, 32'h4E20);
    rchk(8'h04, 32'hE20, "interval field");
    apb(1'b1, 8'h04, 32'h5);
    rchk(8'h04, 32'h5, "interval raw");
    rchk(8'h18, 32'h0, "unmapped");
    `CHK("slave error", 1'b1, er)
    $display("test regs done");
  endtask
  // Gap without epochs and the sentence that follows
  task t_interval;
    int t1;
    wait_lead;
    wait_lead;
    t1 = tlead;
    wait_lead;
    `CHK("gap", 100, tlead - t1)
    tick(12);
    `CHK("tod", tsc - 32'h1, TOD_TIME)
    `CHK("orphan", 1'b0, orphan)
    `CHK("device time", tsc - 32'h1, dev_time)
    rchk(8'h14, tsc - 32'h1, "tod reg");
    $display("test interval done");
  endtask
  // Larger delay moves the pulse earlier after an epoch
  task t_delay;
    int d10;
    apb(1'b1, 8'h08, 32'hA);
    epoch_lead;
    d10 = tlead - tep;
    apb(1'b1, 8'h08, 32'h1E);
    epoch_lead;
    `CHK("delay", d10 - 20, tlead - tep)
    apb(1'b1, 8'h08, 32'h0);
    $display("test delay done");
  endtask
  // Every scale code, then the age limit on the satellite and local scales
  task t_scale;
    int i;
    for (i = 0; i < 4; i++) begin
      apb(1'b1, 8'h00, 1 | (i << 2));
      tick(1);
      `CHK("scale", i[1:0], SCALE_SEL)
    end
    run(32'h1, 16'h14);
    `CHK("stale stops", 0, n)
    rchk(8'h10, 32'h5, "status stale");
    run(32'h9, 16'h14);
    `CHK("local runs", 1'b1, n > 1)
    run(32'h1, 16'h0);
    `CHK("fresh resumes", 1'b1, n > 1)
    $display("test scale done");
  endtask
  // Falling polarity idles high between pulses
  task t_polarity;
    apb(1'b1, 8'h00, 32'h3);
    pol = 1'b1;
    wait_lead;
    wait_lead;
    tick(10);
    `CHK("idle high", 1'b1, PPS_OUT)
    apb(1'b1, 8'h00, 32'h1);
    pol = 1'b0;
    $display("test polarity done");
  endtask
  initial begin
    tick(10);
    RESET_N <= 1'b1;
    t_regs;
    t_interval;
    t_delay;
    t_scale;
    t_polarity;
    report_and_stop;
  end
endmodule
bind ppsg_top ppsg_checker u_chk (.CLK_SYS, .RESET_N, .PSEL, .PENABLE, .PWRITE, .PADDR,
  .PWDATA, .PREADY, .PSLVERR, .SOLUTION_AGE, .SCALE_SEL, .PPS_OUT, .TOD_TIME, .TOD_STROBE);
